// [src/slot_b_frontend_config_regs.v]
// second time slot front end configuration registers, axi4-lite slave
// assumes a single-clock master that keeps the axi4-lite handshakes
// Behaviour
// - bit 9 picks buffer gain 1 or 0.7
// - bit 7 turns integrator into buffer amp
// - bit 6 enables per-channel transimpedance gain
// - individual mode: field drives channel 1 only
// - shared mode: field drives all four channels
// - gain codes 200k, 100k, 50k, 25k ohm
// - bits 5:4 select reference, reset 3
// - path register read/write, resets full path
//
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ns
`include "slot_b_defines.vh"
module slot_b_frontend_config_regs #(
  parameter CHANNELS = 4
) (
  input wire aclk, // system clock, 25 mhz
  input wire aresetn, // synchronous reset, active low
  input wire [11:0] awaddr, // write address
  input wire [2:0] awprot, // write protection, unused
  input wire awvalid, // write address valid
  output wire awready, // write address ready
  input wire [31:0] wdata, // write data
  input wire [3:0] wstrb, // write byte strobes
  input wire wvalid, // write data valid
  output wire wready, // write data ready
  output wire [1:0] bresp, // write response
  output wire bvalid, // write response valid
  input wire bready, // write response ready
  input wire [11:0] araddr, // read address
  input wire [2:0] arprot, // read protection, unused
  input wire arvalid, // read address valid
  output wire arready, // read address ready
  output wire [31:0] rdata, // read data
  output wire [1:0] rresp, // read response
  output wire rvalid, // read data valid
  input wire rready, // read data ready
  input wire [2*CHANNELS-3:0] other_channel_gain, // channels 2 and up
  output wire [5:0] frontend_mode_field, // upper mode field
  output wire second_slot_buffer_gain_sel, // 0 unity, 1 gain 0.7
  output wire second_slot_integrator_bypass, // integrator as buffer
  output wire second_slot_per_channel_gain_en, // individual gain
  output wire [1:0] second_slot_amp_reference_sel, // reference code
  output wire [1:0] second_slot_amp_gain_code, // raw gain field
  output wire [2*CHANNELS-1:0] channel_gain_code, // per channel gain
  output wire [15:0] second_slot_path_code, // path connection code
  output wire full_path_sel, // full analog path selected
  output wire converter_bypass_sel // a bypass path code selected
);
  // stored registers
  reg [15:0] ctrl_reg;
  reg [15:0] path_reg;
  reg [4:0] status_reg;
  wire [4:0] status_next;

  // write channel holding
  reg aw_held_reg;
  reg [11:0] aw_addr_reg;
  reg w_held_reg;
  reg [31:0] w_data_reg;
  reg [3:0] w_strb_reg;
  reg bvalid_reg;
  reg [1:0] bresp_reg;

  // read channel
  reg rvalid_reg;
  reg [1:0] rresp_reg;
  reg [31:0] rdata_reg;
  reg [31:0] rdata_next;
  reg [1:0] rresp_next;

  wire do_write;
  wire do_read;
  wire [9:0] wr_index;
  wire [9:0] rd_index;

  // byte-lane merge of a 16-bit register
  function [15:0] merge16;
    input [15:0] old;
    input [31:0] data;
    input [3:0] strb;
    begin
      merge16[7:0] = strb[0] ? data[7:0] : old[7:0];
      merge16[15:8] = strb[1] ? data[15:8] : old[15:8];
    end
  endfunction

  // handshake outputs
  assign awready = ~aw_held_reg & ~bvalid_reg;
  assign wready = ~w_held_reg & ~bvalid_reg;
  assign arready = ~rvalid_reg;
  assign bvalid = bvalid_reg;
  assign bresp = bresp_reg;
  assign rvalid = rvalid_reg;
  assign rresp = rresp_reg;
  assign rdata = rdata_reg;

  assign do_write = aw_held_reg & w_held_reg & ~bvalid_reg;
  assign do_read = arvalid & ~rvalid_reg;
  assign wr_index = aw_addr_reg[11:2];
  assign rd_index = araddr[11:2];

  // capture address and data in either order
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= 12'h000;
      w_held_reg <= 1'b0;
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
    end else begin
      if (awvalid && awready) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= awaddr;
      end else if (do_write) begin
        aw_held_reg <= 1'b0;
      end
      if (wvalid && wready) begin
        w_held_reg <= 1'b1;
        w_data_reg <= wdata;
        w_strb_reg <= wstrb;
      end else if (do_write) begin
        w_held_reg <= 1'b0;
      end
    end
  end

  // register update and write response
  always @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= `GAIN_BUFFER_CTRL_RESET;
      path_reg <= `PATH_CONNECTION_RESET;
      bvalid_reg <= 1'b0;
      bresp_reg <= `RESP_OKAY;
    end else begin
      if (do_write) begin
        bvalid_reg <= 1'b1;
        case (wr_index)
          `IDX_GAIN_BUFFER_CTRL: begin
            ctrl_reg <= merge16(ctrl_reg, w_data_reg, w_strb_reg);
            bresp_reg <= `RESP_OKAY;
          end
          `IDX_PATH_CONNECTION: begin
            path_reg <= merge16(path_reg, w_data_reg, w_strb_reg);
            bresp_reg <= `RESP_OKAY;
          end
          default: begin
            bresp_reg <= `RESP_SLVERR;
          end
        endcase
      end else if (bvalid_reg && bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // read data selection
  always @* begin
    rdata_next = 32'h00000000;
    rresp_next = `RESP_OKAY;
    case (rd_index)
      `IDX_GAIN_BUFFER_CTRL: begin
        rdata_next = {16'h0000, ctrl_reg};
      end
      `IDX_PATH_CONNECTION: begin
        rdata_next = {16'h0000, path_reg};
      end
      `IDX_PATH_STATUS: begin
        rdata_next = {27'h0000000, status_reg};
      end
      default: begin
        rresp_next = `RESP_SLVERR;
      end
    endcase
  end

  // read response
  always @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rresp_reg <= `RESP_OKAY;
      rdata_reg <= 32'h00000000;
    end else begin
      if (do_read) begin
        rvalid_reg <= 1'b1;
        rresp_reg <= rresp_next;
        rdata_reg <= rdata_next;
      end else if (rvalid_reg && rready) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

  // path code decode into status flags
  assign status_next[`STAT_FULL_BIT] = (path_reg == `PATH_FULL_ANALOG);
  assign status_next[`STAT_BYPASS_BUF_BIT] =
    (path_reg == `PATH_BYPASS_WITH_BUF);
  assign status_next[`STAT_BYPASS_ALT_BIT] = (path_reg == `PATH_BYPASS_ALT);
  assign status_next[`STAT_UNDEFINED_BIT] =
    ~(status_next[`STAT_FULL_BIT] | status_next[`STAT_BYPASS_BUF_BIT] |
      status_next[`STAT_BYPASS_ALT_BIT]);
  // bypass code that disagrees with the integrator-as-buffer bit
  assign status_next[`STAT_MISMATCH_BIT] =
    (status_next[`STAT_BYPASS_BUF_BIT] & ~ctrl_reg[`INT_BYPASS_BIT]) |
    (status_next[`STAT_BYPASS_ALT_BIT] &
     ctrl_reg[`INT_BYPASS_BIT]);

  // registered path status
  always @(posedge aclk) begin
    if (!aresetn) begin
      status_reg <= `PATH_STATUS_RESET;
    end else begin
      status_reg <= status_next;
    end
  end

  // static control outputs straight from the stored fields
  assign frontend_mode_field = ctrl_reg[`MODE_FIELD_HI:`MODE_FIELD_LO];
  assign second_slot_buffer_gain_sel = ctrl_reg[`BUF_GAIN_BIT];
  assign second_slot_integrator_bypass =
    ctrl_reg[`INT_BYPASS_BIT];
  assign second_slot_per_channel_gain_en =
    ctrl_reg[`IND_GAIN_BIT];
  assign second_slot_amp_reference_sel =
    ctrl_reg[`AMP_VREF_HI:`AMP_VREF_LO];
  // code 0..3 maps to 200k, 100k, 50k, 25k ohm in the analog block
  assign second_slot_amp_gain_code =
    ctrl_reg[`AMP_GAIN_HI:`AMP_GAIN_LO];
  assign second_slot_path_code = path_reg;
  assign full_path_sel = status_reg[`STAT_FULL_BIT];
  assign converter_bypass_sel = status_reg[`STAT_BYPASS_BUF_BIT] |
    status_reg[`STAT_BYPASS_ALT_BIT];

  // per-channel gain distribution
  channel_gain_resolver #(
    .CHANNELS(CHANNELS)
  ) u_gain (
    .aclk(aclk),
    .aresetn(aresetn),
    .per_channel_en(ctrl_reg[`IND_GAIN_BIT]),
    .shared_gain(ctrl_reg[`AMP_GAIN_HI:`AMP_GAIN_LO]),
    .other_gain(other_channel_gain),
    .chan_gain(channel_gain_code)
  );
endmodule

// [common/slot_b_defines.vh]
// constants for the second time slot front end configuration registers
// assumes inclusion by bare name from the design files
`ifndef SLOT_B_DEFINES_VH
`define SLOT_B_DEFINES_VH

// register indices; byte address is four times the index
`define IDX_GAIN_BUFFER_CTRL 10'h044
`define IDX_PATH_CONNECTION 10'h045
`define IDX_PATH_STATUS 10'h046

// gain and buffer control field positions
`define MODE_FIELD_HI 15
`define MODE_FIELD_LO 10
`define BUF_GAIN_BIT 9
`define RSVD_ZERO_BIT 8
`define INT_BYPASS_BIT 7
`define IND_GAIN_BIT 6
`define AMP_VREF_HI 5
`define AMP_VREF_LO 4
`define RSVD_PAIR_HI 3
`define RSVD_PAIR_LO 2
`define AMP_GAIN_HI 1
`define AMP_GAIN_LO 0

// reset values
`define GAIN_BUFFER_CTRL_RESET 16'h1C38
`define PATH_CONNECTION_RESET 16'hADA5
`define PATH_STATUS_RESET 5'h01

// defined path codes
`define PATH_FULL_ANALOG 16'hADA5
`define PATH_BYPASS_WITH_BUF 16'hAE65
`define PATH_BYPASS_ALT 16'hB065

// path status bit positions
`define STAT_FULL_BIT 0
`define STAT_BYPASS_BUF_BIT 1
`define STAT_BYPASS_ALT_BIT 2
`define STAT_UNDEFINED_BIT 3
`define STAT_MISMATCH_BIT 4

// bus responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// [src/channel_gain_resolver.v]
// per-channel transimpedance gain codes for the second time slot
// assumes inputs come from flops on the same clock
`timescale 1ns/1ns
module channel_gain_resolver #(
  parameter CHANNELS = 4
) (
  input wire aclk, // system clock
  input wire aresetn, // synchronous reset, active low
  input wire per_channel_en, // individual gain enable
  input wire [1:0] shared_gain, // gain field of the control register
  input wire [2*CHANNELS-3:0] other_gain, // gains of channels 2 and up
  output wire [2*CHANNELS-1:0] chan_gain // two bits per channel
);
  reg [2*CHANNELS-1:0] gain_reg;
  wire [2*CHANNELS-1:0] gain_next;

  // channel 1 always follows the gain field
  assign gain_next[1:0] = shared_gain;

  // remaining channels pick shared or individual code
  genvar i;
  generate
    for (i = 1; i < CHANNELS; i = i + 1) begin : chan
      assign gain_next[2*i+1:2*i] = per_channel_en ?
        other_gain[2*i-1:2*i-2] : shared_gain;
    end
  endgenerate

  // registered outputs
  always @(posedge aclk) begin
    if (!aresetn) begin
      gain_reg <= {2*CHANNELS{1'b0}};
    end else begin
      gain_reg <= gain_next;
    end
  end

  assign chan_gain = gain_reg;
endmodule

// [verif/slot_b_frontend_config_regs_chk.sv]
// checker for the second slot configuration registers
// assumes bind onto the register block, one clock domain
`timescale 1ns/1ns
module slot_b_frontend_config_regs_chk #(
  parameter CHANNELS = 4
) (
  input logic aclk, // clock
  input logic aresetn, // reset, low
  input logic awvalid, // aw valid
  input logic awready, // aw ready
  input logic wvalid, // w valid
  input logic wready, // w ready
  input logic bvalid, // b valid
  input logic bready, // b ready
  input logic arvalid, // ar valid
  input logic arready, // ar ready
  input logic rvalid, // r valid
  input logic rready, // r ready
  input logic [2*CHANNELS-3:0] other_channel_gain, // ch2 up
  input logic second_slot_per_channel_gain_en, // per channel
  input logic [1:0] second_slot_amp_gain_code, // gain field
  input logic [2*CHANNELS-1:0] channel_gain_code, // all channels
  input logic [15:0] second_slot_path_code, // path code
  input logic full_path_sel, // full path
  input logic converter_bypass_sel // bypass path
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // write handshake steps
  sequence s_both_taken;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence s_resp;
    !bvalid ##1 bvalid;
  endsequence
  // gain routing, one cycle behind the fields
  a_ch1_gain: assert property (
    channel_gain_code[1:0] == $past(second_slot_amp_gain_code))
    else $error("channel 1 gain wrong");
  a_shared_gain: assert property (
    !$past(second_slot_per_channel_gain_en) |->
    channel_gain_code[2*CHANNELS-1:2] ==
    $past({(CHANNELS-1){second_slot_amp_gain_code}}))
    else $error("shared gain wrong");
  a_indiv_gain: assert property (
    $past(second_slot_per_channel_gain_en) |->
    channel_gain_code[2*CHANNELS-1:2] == $past(other_channel_gain))
    else $error("individual gain wrong");
  // path decode flags
  a_full_path: assert property (
    full_path_sel == $past(second_slot_path_code == 16'hADA5))
    else $error("full path flag wrong");
  a_bypass_path: assert property (
    converter_bypass_sel == $past(second_slot_path_code == 16'hAE65 ||
    second_slot_path_code == 16'hB065))
    else $error("bypass flag wrong");
  // bus timing
  a_write_lat: assert property (s_both_taken |=> s_resp)
    else $error("write response late");
  a_b_drop: assert property (bvalid && bready |=> !bvalid)
    else $error("bvalid stuck");
  a_busy_ready: assert property (bvalid |-> !awready && !wready)
    else $error("ready during response");
  a_read_lat: assert property (arvalid && arready |=> rvalid)
    else $error("read response late");
  a_r_drop: assert property (rvalid && rready |=> !rvalid && arready)
    else $error("rvalid stuck");
endmodule

// [verif/slot_b_frontend_config_regs_tb_top.sv]
// bench for the second slot configuration registers
// assumes the register block and its checker are compiled alongside
`timescale 1ns/1ns
module slot_b_frontend_config_regs_tb_top;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, full, byp;
  logic buf_gain, int_byp, ind_en;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd_val;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, vref, gain, resp;
  logic [5:0] other_gain, mode;
  logic [7:0] chan_gain;
  logic [15:0] path;
  int errors, num_checks;
  // device under test
  slot_b_frontend_config_regs uut (.aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .other_channel_gain(other_gain), .frontend_mode_field(mode),
    .second_slot_buffer_gain_sel(buf_gain),
    .second_slot_integrator_bypass(int_byp),
    .second_slot_per_channel_gain_en(ind_en),
    .second_slot_amp_reference_sel(vref),
    .second_slot_amp_gain_code(gain), .channel_gain_code(chan_gain),
    .second_slot_path_code(path), .full_path_sel(full),
    .converter_bypass_sel(byp));
  // 25 mhz clock
  initial begin
    aclk = 1'h0;
    forever #20 aclk = ~aclk;
  end
  task report_and_stop;
    if (errors == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one axi4-lite write, address and data offered together
  task wr(input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
      if (bvalid) break;
    end
    resp = bresp;
    bready <= 1'h0;
    if (n >= 50) begin
      errors++;
      report_and_stop;
    end
  endtask
  // one axi4-lite read
  task rd(input logic [11:0] a);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'h0;
      if (rvalid) break;
    end
    rd_val = rdata;
    resp = rresp;
    rready <= 1'h0;
    if (n >= 50) begin
      errors++;
      report_and_stop;
    end
  endtask
  task t_reset;
    rd(12'h110);
    chk("ctrl reset", 32'h1C38, rd_val);
    rd(12'h114);
    chk("path reset", 32'hADA5, rd_val);
    chk("vref reset", 32'h3, vref);
    chk("full reset", 32'h1, full);
    chk("mode reset", 32'h07, mode);
  endtask
  // every gain and reference code, both gain modes
  task t_fields;
    logic [15:0] v;
    for (int i = 0; i < 4; i++) begin
      other_gain <= 6'h2D ^ 6'(i);
      v = {6'h07, i[0], 1'h0, i[1], i[0] ^ i[1], 2'(3 - i), 2'h1,
        2'(i)};
      wr(12'h110, {16'h0, v});
      @(posedge aclk);
      chk("mode", v[15:10], mode);
      chk("buf gain", v[9], buf_gain);
      chk("int bypass", v[7], int_byp);
      chk("ind enable", v[6], ind_en);
      chk("vref", v[5:4], vref);
      chk("gain", v[1:0], gain);
      chk("chan gain", v[6] ? {other_gain, v[1:0]} : {4{v[1:0]}},
        chan_gain);
      rd(12'h110);
      chk("ctrl back", {16'h0, v}, rd_val);
    end
  endtask
  // defined path codes, integrator-as-buffer bit set to suit each code
  task t_path;
    logic [15:0] c [3];
    logic [4:0] s [3];
    c = '{16'hAE65, 16'hB065, 16'hADA5};
    s = '{5'h02, 5'h04, 5'h01};
    for (int k = 0; k < 3; k++) begin
      // bit 7 set for the first bypass code, clear for the other
      wr(12'h110,
        k == 0 ? 32'h1C94 : 32'h1C14);
      wr(12'h114, {16'h0, c[k]});
      @(posedge aclk);
      chk("path out", c[k], path);
      chk("full flag", c[k] == 16'hADA5, full);
      chk("bypass flag", c[k] == 16'hAE65 || c[k] == 16'hB065,
        byp);
      rd(12'h114);
      chk("path back", {16'h0, c[k]}, rd_val);
      rd(12'h118);
      chk("path status", s[k], rd_val);
    end
  endtask
  task t_unmapped;
    wr(12'h200, 32'hFFFF);
    chk("unmapped bresp", 32'h2, resp);
    wr(12'h118, 32'hFFFF);
    chk("status bresp", 32'h2, resp);
    rd(12'h200);
    chk("unmapped rresp", 32'h2, resp);
    chk("unmapped rdata", 32'h0, rd_val);
    rd(12'h114);
    chk("path kept", 32'hADA5, rd_val);
  endtask
  // main sequence with a second reset in mid run
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
    awaddr = 12'h0;
    araddr = 12'h0;
    wdata = 32'h0;
    wstrb = 4'h0;
    other_gain = 6'h1B;
    errors = 0;
    num_checks = 0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'h1;
    t_reset;
    t_fields;
    t_path;
    t_unmapped;
    // leave a bypass code in place so the second reset must restore the full path code
    wr(12'h114, 32'hB065);
    aresetn <= 1'h0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    t_reset;
    report_and_stop;
  end
endmodule
bind slot_b_frontend_config_regs slot_b_frontend_config_regs_chk #(
  .CHANNELS(CHANNELS)) chk (.aclk(aclk), .aresetn(aresetn),
  .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready),
  .bvalid(bvalid), .bready(bready), .arvalid(arvalid), .arready(arready),
  .rvalid(rvalid), .rready(rready), .other_channel_gain(other_channel_gain),
  .second_slot_per_channel_gain_en(second_slot_per_channel_gain_en),
  .second_slot_amp_gain_code(second_slot_amp_gain_code),
  .channel_gain_code(channel_gain_code),
  .second_slot_path_code(second_slot_path_code),
  .full_path_sel(full_path_sel), .converter_bypass_sel(converter_bypass_sel));
